/* File: hdl/advs_map.svh */
// Constants for the converter voltage serial reporter
`ifndef ADVS_MAP_SVH
`define ADVS_MAP_SVH

`define ADVS_CLK_HZ 100000000
`define ADVS_BAUD 9600
`define ADVS_PERIOD_MS 100
`define ADVS_MSG_LEN 26
`define ADVS_SAMPLE_W 12
`define ADVS_SIGN_BIT 11
`define ADVS_MAG_SHIFT 11
`define ADVS_ZERO_CODE 12'h800
`define ADVS_FULL_MV 5000
`define ADVS_FIFO_DEPTH 4
`define ADVS_CH_A 8'h41
`define ADVS_CH_D 8'h44
`define ADVS_CH_ONE 8'h31
`define ADVS_CH_TWO 8'h32
`define ADVS_CH_COLON 8'h3a
`define ADVS_CH_PLUS 8'h2b
`define ADVS_CH_MINUS 8'h2d
`define ADVS_CH_DOT 8'h2e
`define ADVS_CH_VOLT 8'h56
`define ADVS_CH_CR 8'h0d
`define ADVS_CH_LF 8'h0a
`define ADVS_CH_ZERO 8'h30

`endif

/* File: hdl/advs_pkg.sv */
// Types shared by the voltage serial reporter
package advs_pkg;

  typedef enum logic {ADVS_IDLE, ADVS_FILL} advs_phase_e;

  typedef logic [20:0] advs_reading_t;

endpackage : advs_pkg

/* File: hdl/advs_fifo.sv */
// Small flip-flop FIFO between message builder and serial shifter
`timescale 1ns/100ps
module advs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rdPtr;
    logic [PW-1:0] wrPtr;
    logic [CW-1:0] count;
  } advs_fifo_s;

  advs_fifo_s st;
  advs_fifo_s next_st;
  logic doPush;
  logic doPop;

  assign inReady = (st.count != CW'(DEPTH));
  assign outValid = (st.count != '0);
  assign outData = st.mem[st.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_comb begin
    next_st = st;
    if (doPush) begin
      next_st.mem[st.wrPtr] = inData;
      next_st.wrPtr = (st.wrPtr == PW'(DEPTH - 1)) ? '0 : PW'(st.wrPtr + 1'b1);
    end
    if (doPop) begin
      next_st.rdPtr = (st.rdPtr == PW'(DEPTH - 1)) ? '0 : PW'(st.rdPtr + 1'b1);
    end
    if (doPush && !doPop) begin
      next_st.count = CW'(st.count + 1'b1);
    end else if (doPop && !doPush) begin
      next_st.count = CW'(st.count - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : advs_fifo

/* File: hdl/advs_reporter.sv */
// Dual-channel sample capture, voltage conversion and 9600 baud text report
`timescale 1ns/100ps
`include "advs_map.svh"
module advs_reporter
  import advs_pkg::*;
#(
  parameter int PERIOD_CYCLES = `ADVS_PERIOD_MS * (`ADVS_CLK_HZ / 1000),
  parameter int BAUD_DIV = `ADVS_CLK_HZ / `ADVS_BAUD
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic channelOneClk,
  input wire logic [11:0] channelOneSample,
  input wire logic channelTwoClk,
  input wire logic [11:0] channelTwoSample,
  output logic txLine
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0][2:0] clkSync;
    logic [1:0][2:0][11:0] dataSync;
    logic [1:0] clkLvl;
    logic [1:0][11:0] sample;
    logic [31:0] intervalCnt;
    advs_phase_e phase;
    logic [4:0] charIdx;
    advs_reading_t snapOne;
    advs_reading_t snapTwo;
    logic txBusy;
    logic [8:0] txShift;
    logic [3:0] bitsLeft;
    logic [15:0] baudCnt;
    logic txLine;
  } advs_state_s;

  advs_state_s st;
  advs_state_s next_st;
  advs_reading_t reading [2];
  logic [7:0] pushData;
  logic pushReady;
  logic popValid;
  logic [7:0] popData;
  logic baudTick;

  // ----------------------------------------
  // Conversion
  // ----------------------------------------
  function automatic logic [19:0] toBcd(input logic [15:0] bin);
    logic [35:0] w;
    w = {20'h0, bin};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (w[16 + 4 * j +: 4] > 4'h4) begin
          w[16 + 4 * j +: 4] = 4'(w[16 + 4 * j +: 4] + 4'h3);
        end
      end
      w = {w[34:0], 1'b0};
    end
    return w[35:16];
  endfunction : toBcd

  function automatic advs_reading_t toReading(input logic [11:0] s);
    logic [11:0] mag;
    logic [15:0] milliVolt;
    // Offset binary: codes below the zero code are negative, distance to it is the size
    mag = s[`ADVS_SIGN_BIT] ? {1'b0, s[10:0]} : 12'(`ADVS_ZERO_CODE - {1'b0, s[10:0]});
    milliVolt = 16'((32'(mag) * `ADVS_FULL_MV) >> `ADVS_MAG_SHIFT);
    return {s[`ADVS_SIGN_BIT], toBcd(milliVolt)};
  endfunction : toReading

  always_comb begin
    reading[0] = toReading(st.sample[0]);
    reading[1] = toReading(st.sample[1]);
  end

  // ----------------------------------------
  // Character map
  // ----------------------------------------
  function automatic logic [7:0] charAt(input logic [4:0] idx, input advs_reading_t r,
                                        input logic [7:0] label);
    logic [7:0] c;
    case (idx)
      5'h00: c = `ADVS_CH_A;
      5'h01: c = `ADVS_CH_D;
      5'h02: c = label;
      5'h03: c = `ADVS_CH_COLON;
      5'h04: c = r[20] ? `ADVS_CH_PLUS : `ADVS_CH_MINUS;
      5'h05: c = `ADVS_CH_ZERO | {4'h0, r[19:16]};
      5'h06: c = `ADVS_CH_ZERO | {4'h0, r[15:12]};
      5'h07: c = `ADVS_CH_DOT;
      5'h08: c = `ADVS_CH_ZERO | {4'h0, r[11:8]};
      5'h09: c = `ADVS_CH_ZERO | {4'h0, r[7:4]};
      5'h0a: c = `ADVS_CH_ZERO | {4'h0, r[3:0]};
      default: c = `ADVS_CH_VOLT;
    endcase
    return c;
  endfunction : charAt

  always_comb begin
    if (st.charIdx < 5'h0c) begin
      pushData = charAt(st.charIdx, st.snapOne, `ADVS_CH_ONE);
    end else if (st.charIdx < 5'h18) begin
      pushData = charAt(5'(st.charIdx - 5'h0c), st.snapTwo, `ADVS_CH_TWO);
    end else if (st.charIdx == 5'h18) begin
      pushData = `ADVS_CH_CR;
    end else begin
      pushData = `ADVS_CH_LF;
    end
  end

  assign baudTick = (st.baudCnt == 16'(BAUD_DIV - 1));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Three-stage pin synchronisers; a converter edge counts once stages two and three agree
    next_st.clkSync[0] = {st.clkSync[0][1:0], channelOneClk};
    next_st.clkSync[1] = {st.clkSync[1][1:0], channelTwoClk};
    next_st.dataSync[0] = {st.dataSync[0][1:0], channelOneSample};
    next_st.dataSync[1] = {st.dataSync[1][1:0], channelTwoSample};
    for (int c = 0; c < 2; c++) begin
      if (st.clkSync[c][1] == st.clkSync[c][2]) begin
        next_st.clkLvl[c] = st.clkSync[c][2];
        if (st.clkSync[c][2] && !st.clkLvl[c]) begin
          next_st.sample[c] = st.dataSync[c][2];
        end
      end
    end

    // Message pacing and building
    if (st.intervalCnt == 32'(PERIOD_CYCLES - 1)) begin
      next_st.intervalCnt = '0;
    end else begin
      next_st.intervalCnt = 32'(st.intervalCnt + 1'b1);
    end
    case (st.phase)
      ADVS_IDLE: begin
        if (st.intervalCnt == 32'(PERIOD_CYCLES - 1)) begin
          next_st.snapOne = reading[0];
          next_st.snapTwo = reading[1];
          next_st.charIdx = '0;
          next_st.phase = ADVS_FILL;
        end
      end
      ADVS_FILL: begin
        // A slow line stalls the builder through the FIFO instead of dropping text
        if (pushReady) begin
          if (st.charIdx == 5'(`ADVS_MSG_LEN - 1)) begin
            next_st.phase = ADVS_IDLE;
          end else begin
            next_st.charIdx = 5'(st.charIdx + 1'b1);
          end
        end
      end
      default: next_st.phase = ADVS_IDLE;
    endcase

    // Serial shifter with its own baud divider
    if (!st.txBusy) begin
      next_st.baudCnt = '0;
      next_st.txLine = 1'b1;
      if (popValid) begin
        next_st.txBusy = 1'b1;
        next_st.txLine = 1'b0;
        next_st.txShift = {1'b1, popData};
        next_st.bitsLeft = 4'h9;
      end
    end else begin
      next_st.baudCnt = baudTick ? '0 : 16'(st.baudCnt + 1'b1);
      if (baudTick) begin
        if (st.bitsLeft != 4'h0) begin
          next_st.txLine = st.txShift[0];
          next_st.txShift = {1'b1, st.txShift[8:1]};
          next_st.bitsLeft = 4'(st.bitsLeft - 1'b1);
        end else begin
          next_st.txBusy = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
      st.txLine <= 1'b1;
      st.phase <= ADVS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign txLine = st.txLine;

  advs_fifo #(
    .WIDTH(8),
    .DEPTH(`ADVS_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .inValid(st.phase == ADVS_FILL),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(popValid),
    .outReady(!st.txBusy),
    .outData(popData)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence lastCharPushed;
    st.phase == ADVS_FILL && pushReady && st.charIdx == 5'h19;
  endsequence

  a_start_bit_low: assert property ($rose(st.txBusy) |-> !st.txLine)
    else $error("start bit not low");
  a_idle_line_high: assert property (!st.txBusy && !$fell(st.txBusy) |-> st.txLine)
    else $error("idle line not high");
  a_stop_bit_high: assert property (st.txBusy && st.bitsLeft == 4'h0 |-> st.txLine)
    else $error("stop bit not high");
  a_bit_hold_time: assert property (st.txBusy && !baudTick |=> $stable(st.txLine))
    else $error("line changed between baud ticks");
  a_message_end: assert property (lastCharPushed |=> st.phase == ADVS_IDLE)
    else $error("message did not end after 26 characters");
  a_snapshot_hold: assert property (st.phase == ADVS_FILL |=> $stable(st.snapOne)
                                     && $stable(st.snapTwo))
    else $error("readings changed within a message");
  a_sign_char: assert property (st.phase == ADVS_FILL && st.charIdx == 5'h04
                                |-> pushData == (st.snapOne[20] ? 8'h2b : 8'h2d))
    else $error("wrong sign character");
  a_capture_edge: assert property ($rose(st.clkLvl[0]) |-> st.sample[0]
                                    == $past(st.dataSync[0][2]))
    else $error("sample not taken on converter edge");
  a_zero_code: assert property (st.sample[0] == 12'h800 |-> reading[0] == 21'h100000)
    else $error("zero code not read as plus zero");

endmodule : advs_reporter

/* File: tb/advs_terminal.sv */
// Serial terminal model that receives the reporter's text line
`timescale 1ns/100ps
module advs_terminal #(
  parameter int BAUD_DIV = 4
) (
  input wire logic clk,
  input wire logic txLine,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic frameErr
);
  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Mid-bit sampling, so a wrong bit time garbles the byte
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    frameErr = 1'b0;
    forever begin
      @(posedge clk);
      if (txLine === 1'b0) begin
        repeat (BAUD_DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BAUD_DIV) @(posedge clk);
          rxByte[i] <= txLine;
        end
        repeat (BAUD_DIV) @(posedge clk);
        frameErr <= (txLine !== 1'b1);
        rxValid <= 1'b1;
        @(posedge clk);
        rxValid <= 1'b0;
      end
    end
  end
endmodule : advs_terminal

/* File: tb/tb.sv */
// Self-checking bench for the voltage serial reporter
`timescale 1ns/100ps
`include "advs_map.svh"
module tb;
  localparam int PERIOD = 2000;
  localparam int DIV = 4;
  logic clk, srst, oneClk, twoClk, txLine, rxValid, frameErr;
  logic [11:0] oneSample, twoSample, prevA, prevB, nextA, nextB;
  logic [7:0] rxByte;
  int mismatches, testsRun, cyc, lastStart;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  advs_reporter #(.PERIOD_CYCLES(PERIOD), .BAUD_DIV(DIV)) advs_reporter_inst (
    .clk(clk), .srst(srst), .channelOneClk(oneClk), .channelOneSample(oneSample),
    .channelTwoClk(twoClk), .channelTwoSample(twoSample), .txLine(txLine));
  advs_terminal #(.BAUD_DIV(DIV)) advs_terminal_inst (
    .clk(clk), .txLine(txLine), .rxByte(rxByte), .rxValid(rxValid), .frameErr(frameErr));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("mismatches=%0d tests_run=%0d", mismatches, testsRun);
    if (mismatches == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  // Converter words are held well clear of their clock edge
  // Each channel's word is wrong at the other channel's edge, so a crossed clock shows
  task automatic load(input logic [11:0] a, input logic [11:0] b);
    @(negedge clk);
    oneClk = 1'b0;
    twoClk = 1'b0;
    repeat (5) @(negedge clk);
    oneSample = a;
    twoSample = ~b;
    repeat (5) @(negedge clk);
    oneClk = 1'b1;
    repeat (5) @(negedge clk);
    oneSample = ~a;
    twoSample = b;
    repeat (5) @(negedge clk);
    twoClk = 1'b1;
    repeat (5) @(negedge clk);
  endtask : load
  task automatic get_byte();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rxValid !== 1'b1 && n < 2 * PERIOD);
    if (n >= 2 * PERIOD) begin
      mismatches++;
      complete_run();
    end
  endtask : get_byte
  // Sign from the top bit, magnitude from the low 11 bits, 5000 mV full scale
  function automatic logic [7:0] exp_char(logic [11:0] a, logic [11:0] b, int idx);
    logic [11:0] s, mag;
    int mv, k;
    s = (idx < 12) ? a : b;
    k = idx % 12;
    mag = s[11] ? {1'b0, s[10:0]} : 12'h800 - {1'b0, s[10:0]};
    mv = (mag * 5000) >> 11;
    if (idx == 24) return `ADVS_CH_CR;
    if (idx == 25) return `ADVS_CH_LF;
    case (k)
      0: return `ADVS_CH_A;
      1: return `ADVS_CH_D;
      2: return (idx < 12) ? `ADVS_CH_ONE : `ADVS_CH_TWO;
      3: return `ADVS_CH_COLON;
      4: return s[11] ? `ADVS_CH_PLUS : `ADVS_CH_MINUS;
      5: return `ADVS_CH_ZERO + 8'(mv / 10000);
      6: return `ADVS_CH_ZERO + 8'((mv / 1000) % 10);
      7: return `ADVS_CH_DOT;
      8: return `ADVS_CH_ZERO + 8'((mv / 100) % 10);
      9: return `ADVS_CH_ZERO + 8'((mv / 10) % 10);
      10: return `ADVS_CH_ZERO + 8'(mv % 10);
      default: return `ADVS_CH_VOLT;
    endcase
  endfunction : exp_char
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [11:0] corners [6];
    corners = '{12'h800, 12'hfff, 12'h000, 12'h7ff, 12'hfff, 12'h001};
    mismatches = 0;
    testsRun = 0;
    srst = 1'b1;
    oneClk = 1'b0;
    twoClk = 1'b0;
    oneSample = 12'h000;
    twoSample = 12'h000;
    void'($urandom(82));
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    check(txLine, 1'b1);
    prevA = corners[0];
    prevB = corners[1];
    load(prevA, prevB);
    for (int it = 0; it < 9; it++) begin
      get_byte();
      check({frameErr, rxByte}, {1'b0, exp_char(prevA, prevB, 0)});
      if (it > 0) check(cyc - lastStart, PERIOD);
      lastStart = cyc;
      // New words mid-line must not reach this line
      nextA = (it < 2) ? corners[2 * it + 2] : 12'($urandom);
      nextB = (it < 2) ? corners[2 * it + 3] : 12'($urandom);
      load(nextA, nextB);
      for (int idx = 1; idx < 26; idx++) begin
        get_byte();
        check({frameErr, rxByte}, {1'b0, exp_char(prevA, prevB, idx)});
      end
      prevA = nextA;
      prevB = nextB;
    end
    complete_run();
  end
endmodule : tb
